// *** design/sleep_stop_pkg.sv ***
package sleep_stop_pkg;

  // register map, byte addresses on the 8-bit register port
  localparam logic [7:0] SLEEP_CTRL_ADDR   = 8'hDE;
  localparam logic [7:0] SYSCLK_MODE_ADDR  = 8'hE0;
  localparam logic [7:0] STATUS_ADDR       = 8'hE1;
  localparam logic [7:0] INTERVAL_CLK_ADDR = 8'hF4;

  // field positions
  localparam int SLEEP_BIT     = 0;
  localparam int CNT_CLEAR_BIT = 3;
  localparam int SEL_W         = 3;
  localparam int SYSCLK_MODE_REG_W        = 4;
  localparam int SUB_SEL_BIT   = 1;

  // reset values
  localparam logic             SLEEP_RESET = 1'b0;
  localparam logic [SYSCLK_MODE_REG_W-1:0] SYSCLK_MODE_REG_RESET = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RESET   = 3'h7;
  localparam logic [SEL_W-1:0] SEL_MAX     = 3'h7;
  localparam logic [1:0]       MAIN_OFF_CODE = 2'h3;
  localparam logic [7:0]       READ_ZERO   = 8'h00;

  // interrupt request lines
  localparam int IRQ_W       = 8;
  localparam int IRQ_EXT     = 0;
  localparam int IRQ_KEYSCAN = 1;
  localparam int IRQ_SERIAL  = 2;
  localparam int IRQ_WATCH   = 3;
  localparam int IRQ_EVTIMER = 4;
  localparam int IRQ_INTERVAL = 5;
  localparam int IRQ_TIMER0  = 6;
  localparam int IRQ_TIMER1  = 7;
  localparam logic [IRQ_W-1:0] STOP_WAKE_MASK = 8'h1F;

  // stabilisation: counts of the interval timer and log2 of its smallest divide
  localparam int STAB_COUNT        = 256;
  localparam int MIN_DIV_LOG2_DOC  = 3;
  localparam int TIMER_NUM         = 2;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_STOP  = 4'b0100,
    ST_STAB  = 4'b1000
  } pwr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic                 cpuClkEn;
    logic                 sysClkEn;
    logic                 periClkEn;
    logic                 mainOscEn;
    logic                 subOscEn;
    logic                 xinForceLow;
    logic                 portFreeze;
    logic                 intervalRun;
    logic [TIMER_NUM-1:0] timerRun;
  } clk_ctrl_t;

endpackage

// *** design/sleep_stop_power_control.sv ***
// Behaviour
// - writing bit0 at 0xDE enters sleep
// - sleep stops CPU and system clocks only
// - reset or any interrupt ends sleep
// - reset: clear timer, wait 256 slow counts
// - stop request halts main, system, peripheral clocks
// - stop keeps RAM and control registers
// - ports keep driving held values in stop
// - timers halt in stop unless event counting
// - stop forces oscillator pins low
// - only listed sources release stop
// - sleep release restores CPU clock
// - sub mode: main oscillator off only at 11
// - clock enables follow the mode table
// - reset wake reinitialises registers, keeps RAM
// - stop release runs stabilisation, all held
// - interval select bits pick count rate
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module sleep_stop_power_control
  import sleep_stop_pkg::*;
#(
  parameter int CNT_WIDTH    = 8,
  parameter int MIN_DIV_LOG2 = MIN_DIV_LOG2_DOC
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // register port
  input  wire reg_req_t             regReq,
  output logic [7:0]                regRdData,
  // cpu and interrupt side
  input  wire logic                 stopExec,
  input  wire logic [IRQ_W-1:0]     irqReq,
  input  wire logic [TIMER_NUM-1:0] eventMode,
  // clock and hold controls
  output clk_ctrl_t                 clkCtrl
);

  // prescaler covers the base divide plus the widest select step
  localparam int PW = MIN_DIV_LOG2 + int'(SEL_MAX);

  // refused at elaboration: the count must fit the byte-wide read port
  if (CNT_WIDTH < 2 || CNT_WIDTH > 8) begin : gen_cnt_width_check
    $error("CNT_WIDTH must lie in 2..8");
  end
  // a larger base divide would overshoot the slowest rate
  if (MIN_DIV_LOG2 < 0 || MIN_DIV_LOG2 > MIN_DIV_LOG2_DOC) begin : gen_min_div_check
    $error("MIN_DIV_LOG2 must lie in 0..3");
  end

  typedef struct packed {
    pwr_state_t            state;
    logic                  sleepBit;
    logic [SYSCLK_MODE_REG_W-1:0]     sysclkMode;
    logic [SEL_W-1:0]      intervalSel;
    logic [CNT_WIDTH-1:0]  intervalCnt;
    logic [PW-1:0]         presc;
    logic [7:0]            rdData;
    clk_ctrl_t             ctrl;
  } core_regs_t;

  // enables while reset is low: oscillator on so the settling count can run
  localparam clk_ctrl_t CTRL_AT_RESET = '{
    cpuClkEn:    1'b0,
    sysClkEn:    1'b0,
    periClkEn:   1'b0,
    mainOscEn:   1'b1,
    subOscEn:    1'b1,
    xinForceLow: 1'b0,
    portFreeze:  1'b1,
    intervalRun: 1'b1,
    timerRun:    '0
  };

  // slowest rate and cleared count after reset
  localparam core_regs_t REGS_AT_RESET = '{
    state:       ST_STAB,
    sleepBit:    SLEEP_RESET,
    sysclkMode:  SYSCLK_MODE_REG_RESET,
    intervalSel: SEL_RESET,
    intervalCnt: '0,
    presc:       '0,
    rdData:      READ_ZERO,
    ctrl:        CTRL_AT_RESET
  };

  core_regs_t cur_ff;
  core_regs_t nxt_cur;

  // enables for one mode, after the table of clock states
  function automatic clk_ctrl_t ctrl_for(input pwr_state_t st,
                                         input logic [SYSCLK_MODE_REG_W-1:0] mode,
                                         input logic [TIMER_NUM-1:0] evt);
    clk_ctrl_t c;
    logic      mainOn;
    c      = '0;
    // main oscillator off only when mode code is 11
    mainOn = (mode[1:0] != MAIN_OFF_CODE);
    c.subOscEn = 1'b1;
    case (st)
      ST_RUN: begin
        c.cpuClkEn    = 1'b1;
        c.sysClkEn    = 1'b1;
        c.periClkEn   = 1'b1;
        c.mainOscEn   = mainOn;
        c.intervalRun = 1'b1;
        c.timerRun    = '1;
      end

      ST_SLEEP: begin
        // cpu and system clocks off, sub oscillator and peripherals on, main oscillator off only at mode code 11
        c.periClkEn   = 1'b1;
        c.mainOscEn   = mainOn;
        c.intervalRun = 1'b1;
        c.timerRun    = '1;
      end

      ST_STOP: begin
        // main oscillator, system and peripheral clocks off
        c.mainOscEn   = 1'b0;
        c.xinForceLow = 1'b1;
        c.portFreeze  = 1'b1;
        c.timerRun    = evt;
      end

      ST_STAB: begin
        c.mainOscEn   = 1'b1;
        c.portFreeze  = 1'b1;
        c.intervalRun = 1'b1;
      end

      default: begin
        c.mainOscEn   = 1'b1;
      end
    endcase
    return c;
  endfunction

  logic [PW-1:0]      selMask;
  logic               tick;
  logic               cntWrap;
  logic               sleepReq;
  logic               sleepWake;
  logic               stopWake;
  logic               cntClear;
  logic [7:0]         statusWord;

  always_comb begin
    // select bits set the divide of the count rate
    selMask    = {PW{1'b1}} >> (SEL_MAX - cur_ff.intervalSel);
    tick       = &(cur_ff.presc | ~selMask);
    // settling ends on the wrap, so a full count always passes
    cntWrap    = tick && (&cur_ff.intervalCnt);
    // sleep entry by writing bit 0
    sleepReq   = regReq.wr && (regReq.addr == SLEEP_CTRL_ADDR)
                 && regReq.wrData[SLEEP_BIT];
    // any interrupt line wakes from sleep
    // enables are applied on the cpu side before the lines arrive
    sleepWake  = |irqReq;
    // stop is released only by the listed sources
    stopWake   = |(irqReq & STOP_WAKE_MASK);
    // a write with the clear bit restarts count and prescaler
    cntClear   = regReq.wr && (regReq.addr == INTERVAL_CLK_ADDR)
                 && regReq.wrData[CNT_CLEAR_BIT];
    // one-hot state word, read-only
    statusWord = {4'h0, cur_ff.state};
  end

  always_comb begin
    nxt_cur = cur_ff;

    // interval timer, halted only while stopped
    // stop turns off the clock that feeds it
    if (cur_ff.state != ST_STOP) begin
      nxt_cur.presc = cur_ff.presc + PW'(1);
      if (tick) begin
        nxt_cur.intervalCnt = cur_ff.intervalCnt + CNT_WIDTH'(1);
      end
    end

    // register writes; control registers are untouched by stop
    if (regReq.wr) begin
      case (regReq.addr)
        SLEEP_CTRL_ADDR: begin
          nxt_cur.sleepBit = regReq.wrData[SLEEP_BIT];
        end
        SYSCLK_MODE_ADDR: begin
          nxt_cur.sysclkMode = regReq.wrData[SYSCLK_MODE_REG_W-1:0];
        end
        INTERVAL_CLK_ADDR: begin
          nxt_cur.intervalSel = regReq.wrData[SEL_W-1:0];
        end
        default: begin
          nxt_cur.sleepBit = cur_ff.sleepBit;
        end
      endcase
    end

    // clear bit is self-clearing: it only restarts count and prescaler
    if (cntClear) begin
      nxt_cur.intervalCnt = '0;
      nxt_cur.presc       = '0;
    end

    // mode sequencing
    case (cur_ff.state)
      ST_RUN: begin
        // a stop instruction beats a sleep write in one cycle
        if (stopExec) begin
          nxt_cur.state = ST_STOP;
        end else if (sleepReq && !sleepWake) begin
          nxt_cur.state = ST_SLEEP;
        end else if (sleepReq) begin
          // request already pending: the wake wins, sleep bit drops
          nxt_cur.sleepBit = 1'b0;
        end
      end

      ST_SLEEP: begin
        if (sleepWake) begin
          // oscillator kept running, so no settling wait
          nxt_cur.state    = ST_RUN;
          nxt_cur.sleepBit = 1'b0;
        end
      end

      ST_STOP: begin
        // registers and memory simply keep their contents
        if (stopWake) begin
          // restart the count for the settling interval
          nxt_cur.state       = ST_STAB;
          nxt_cur.intervalCnt = '0;
          nxt_cur.presc       = '0;
        end
      end

      ST_STAB: begin
        // writes still land here; the cpu is held so none arrive
        // settle until the counter wraps past all ones
        if (cntWrap) begin
          nxt_cur.state = ST_RUN;
        end
      end

      default: begin
        nxt_cur.state = ST_STAB;
      end
    endcase

    // read data stand in the cycle after the strobe only
    nxt_cur.rdData = READ_ZERO;
    if (regReq.rd) begin
      case (regReq.addr)
        // unused bits read as zero
        SLEEP_CTRL_ADDR: begin
          nxt_cur.rdData = {7'h00, cur_ff.sleepBit};
        end
        SYSCLK_MODE_ADDR: begin
          nxt_cur.rdData = {4'h0, cur_ff.sysclkMode};
        end
        STATUS_ADDR: begin
          nxt_cur.rdData = statusWord;
        end
        INTERVAL_CLK_ADDR: begin
          nxt_cur.rdData = 8'(cur_ff.intervalCnt);
        end
        default: begin
          nxt_cur.rdData = READ_ZERO;
        end
      endcase
    end

    // clock enables follow the next mode
    // taken from the next state so every enable is a flop output
    nxt_cur.ctrl = ctrl_for(nxt_cur.state, nxt_cur.sysclkMode, eventMode);
  end

  // reset reinitialises control state; memory lives elsewhere
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= REGS_AT_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // both outputs come straight from the state register
  assign regRdData = cur_ff.rdData;
  assign clkCtrl   = cur_ff.ctrl;

endmodule

// *** testbench/sleep_stop_power_control_monitor.sv ***
`timescale 1ns/100ps
module sleep_stop_power_control_monitor
  import sleep_stop_pkg::*;
#(
  parameter int CNT_WIDTH    = 8,
  parameter int MIN_DIV_LOG2 = 3
) (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire reg_req_t             regReq,
  input wire logic [7:0]           regRdData,
  input wire logic                 stopExec,
  input wire logic [IRQ_W-1:0]     irqReq,
  input wire logic [TIMER_NUM-1:0] eventMode,
  input wire clk_ctrl_t            clkCtrl
);
  wire logic slp = clkCtrl.periClkEn && !clkCtrl.sysClkEn;
  wire logic stp = clkCtrl.xinForceLow;
  wire logic wakeStp = (irqReq & STOP_WAKE_MASK) != '0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_SLEEP_ENTRY: assert property (
    clkCtrl.cpuClkEn && regReq.wr && regReq.addr == SLEEP_CTRL_ADDR && regReq.wrData[SLEEP_BIT]
    && irqReq == '0 && !stopExec |=> slp && !clkCtrl.cpuClkEn && clkCtrl.subOscEn) else $error("no sleep");
  AST_SLEEP_WAKE: assert property (
    slp && irqReq != '0 |=> clkCtrl.cpuClkEn) else $error("sleep wake late");
  AST_SLEEP_TIMERS: assert property (
    slp |-> clkCtrl.timerRun == '1 && clkCtrl.intervalRun) else $error("timers halted in sleep");
  AST_STOP_ENTRY: assert property (
    clkCtrl.cpuClkEn && stopExec |=> stp && !clkCtrl.mainOscEn && !clkCtrl.sysClkEn
    && !clkCtrl.periClkEn && clkCtrl.subOscEn && clkCtrl.portFreeze) else $error("bad stop entry");
  AST_STOP_TIMERS: assert property (
    stp && $stable(eventMode) |-> clkCtrl.timerRun == eventMode && !clkCtrl.intervalRun)
    else $error("stop timer run wrong");
  AST_STOP_HOLD: assert property (
    stp && !wakeStp |=> stp) else $error("stop left without source");
  AST_STOP_WAKE: assert property (
    stp && wakeStp |=> !stp && clkCtrl.mainOscEn && !clkCtrl.cpuClkEn && !clkCtrl.periClkEn
    && clkCtrl.portFreeze) else $error("bad stop release");
  AST_RUN_CLOCKS: assert property (
    clkCtrl.cpuClkEn |-> clkCtrl.sysClkEn && clkCtrl.periClkEn && clkCtrl.subOscEn && !clkCtrl.portFreeze)
    else $error("run clocks wrong");
  COV_SLEEP_WAKE: cover property (slp ##1 clkCtrl.cpuClkEn);
  COV_STOP_WAKE: cover property (stp ##1 !stp);
  COV_STAB_DONE: cover property (!clkCtrl.cpuClkEn && !stp ##1 clkCtrl.cpuClkEn);
endmodule
bind sleep_stop_power_control sleep_stop_power_control_monitor #(
  .CNT_WIDTH(CNT_WIDTH), .MIN_DIV_LOG2(MIN_DIV_LOG2)
) mon_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
  .stopExec(stopExec), .irqReq(irqReq), .eventMode(eventMode), .clkCtrl(clkCtrl)
);

// *** testbench/sleep_stop_cpu_model.sv ***
`timescale 1ns/100ps
module sleep_stop_cpu_model
  import sleep_stop_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset_n,
  input wire logic             cpuClkEn,
  input wire logic             stopCmd,
  input wire logic [IRQ_W-1:0] irqEn,
  input wire logic [IRQ_W-1:0] irqSrc,
  output logic                 stopExec,
  output logic [IRQ_W-1:0]     irqReq
);
  logic [1:0] nop_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopExec <= 1'b0;
      irqReq <= '0;
      nop_ff <= 2'h0;
    end else begin
      irqReq <= irqSrc & irqEn;
      stopExec <= stopCmd && cpuClkEn && nop_ff == 2'h0;
      nop_ff <= stopExec ? 2'h2 : nop_ff - {1'b0, nop_ff != 2'h0};
    end
  end
endmodule

// *** testbench/sleep_stop_power_control_tb_top.sv ***
`timescale 1ns/100ps
module sleep_stop_power_control_tb_top
  import sleep_stop_pkg::*;
;
  typedef struct {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e; logic o;} row_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, stopCmd = 1'b0, stopExec;
  reg_req_t regReq = '0;
  logic [7:0] regRdData, irqReq, rd, irqSrc = '0, irqEn = 8'hFF;
  logic [1:0] eventMode = 2'b01;
  clk_ctrl_t clkCtrl;
  int mismatches = 0, checks = 0, n;
  row_t rows [5] = '{'{8'hE0, 8'h02, 1, 8'h02, 1}, '{8'hE0, 8'h03, 1, 8'h03, 0},
    '{8'hE0, 8'h04, 1, 8'h04, 1}, '{8'h33, 8'hFF, 1, 8'h00, 1}, '{STATUS_ADDR, 8'h00, 0, 8'h01, 1}};
  always #4 sys_clk = ~sys_clk;
  sleep_stop_power_control #(.CNT_WIDTH(3), .MIN_DIV_LOG2(0)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .regReq(regReq), .regRdData(regRdData), .stopExec(stopExec), .irqReq(irqReq), .eventMode(eventMode),
    .clkCtrl(clkCtrl));
  sleep_stop_cpu_model cpu_u (.sys_clk(sys_clk), .reset_n(reset_n), .cpuClkEn(clkCtrl.cpuClkEn),
    .stopCmd(stopCmd), .irqEn(irqEn), .irqSrc(irqSrc), .stopExec(stopExec), .irqReq(irqReq));
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: d, wr: w, rd: !w};
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b0, rd: 1'b0};
    #1;
    rd = regRdData;
  endtask
  task automatic pulse(input int b, input logic s);
    @(posedge sys_clk);
    irqSrc <= s ? 8'h00 : 8'h01 << b;
    stopCmd <= s;
    @(posedge sys_clk);
    irqSrc <= 8'h00;
    stopCmd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (clkCtrl.cpuClkEn !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("ERROR t=%0t run wait expired", $time);
      give_verdict();
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    chk({clkCtrl.cpuClkEn, clkCtrl.mainOscEn, clkCtrl.portFreeze}, 8'h03);
    reset_n <= 1'b1;
    repeat (900) @(posedge sys_clk);
    #1;
    chk(clkCtrl.cpuClkEn, 8'h00);
    wait_run(300);
    chk(8'(n), 8'h7C);
    foreach (rows[i]) begin
      if (rows[i].w)
        acc(rows[i].a, rows[i].d, 1'b1);
      acc(rows[i].a, 8'h00, 1'b0);
      chk(rd, rows[i].e);
      chk(clkCtrl.mainOscEn, rows[i].o);
    end
    for (int b = 0; b < IRQ_W; b++) begin
      acc(SLEEP_CTRL_ADDR, 8'h01, 1'b1);
      chk({clkCtrl.cpuClkEn, clkCtrl.sysClkEn, clkCtrl.periClkEn, clkCtrl.mainOscEn}, 8'h03);
      pulse(b, 1'b0);
      chk(clkCtrl.cpuClkEn, 8'h01);
      acc(SLEEP_CTRL_ADDR, 8'h00, 1'b0);
      chk(rd, 8'h00);
    end
    // wake request beside the sleep write wins; the model delays irqSrc one edge
    @(posedge sys_clk);
    irqSrc <= 8'h80;
    @(posedge sys_clk);
    irqSrc <= 8'h00;
    regReq <= '{addr: SLEEP_CTRL_ADDR, wrData: 8'h01, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq <= '{addr: SLEEP_CTRL_ADDR, wrData: 8'h01, wr: 1'b0, rd: 1'b0};
    #1;
    chk(clkCtrl.cpuClkEn, 8'h01);
    acc(SLEEP_CTRL_ADDR, 8'h00, 1'b0);
    chk(rd, 8'h00);
    acc(INTERVAL_CLK_ADDR, 8'h08, 1'b1);
    for (int b = 0; b < 5; b++) begin
      pulse(0, 1'b1);
      chk({clkCtrl.mainOscEn, clkCtrl.xinForceLow, clkCtrl.portFreeze, clkCtrl.periClkEn}, 8'h06);
      chk(clkCtrl.timerRun, {6'h0, eventMode});
      pulse(IRQ_INTERVAL, 1'b0);
      chk(clkCtrl.xinForceLow, 8'h01);
      acc(SYSCLK_MODE_ADDR, 8'h00, 1'b0);
      chk(rd, 8'h04);
      pulse(b, 1'b0);
      chk({clkCtrl.mainOscEn, clkCtrl.cpuClkEn, clkCtrl.portFreeze}, 8'h05);
      wait_run(40);
      chk(8'(n), 8'h08);
    end
    pulse(0, 1'b1);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    eventMode <= 2'b10;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    wait_run(1100);
    acc(SYSCLK_MODE_ADDR, 8'h00, 1'b0);
    chk(rd, {4'h0, SYSCLK_MODE_REG_RESET});
    give_verdict();
  end
endmodule
